// File: logic/ddr_burst4_cfg.svh
// Constants for the burst-of-four common-I/O SRAM port: timing, register map, fields.
// Assumes a 20 MHz system clock; included by the package and the port module.
`ifndef DDR_BURST4_CFG_SVH
`define DDR_BURST4_CFG_SVH

`define CLK_MHZ        20
`define STOP_NS        30
`define STOP_CYC       ((`STOP_NS * `CLK_MHZ + 999) / 1000)
`define LOCK_KCYC      2048
`define RD_WAIT_LAST   2'h2
`define WR_WAIT_LAST   2'h1
`define LANE_W         9

`define REG_STATUS     4'h0
`define REG_CTRL       4'h4
`define REG_LOCKCNT    4'h8
`define ST_LOCKED      0
`define ST_BYPASS      1
`define ST_STOPPED     2
`define ST_BUSY        3
`define CTRL_ENABLE    0
`define CTRL_RELOCK    1
`define CTRL_RESET     1'h1

`endif

// File: logic/ddr_burst4_pkg.sv
// Types shared by the burst-of-four SRAM port and its surroundings.
// Assumes the constants header sits beside it on the include path.
package ddr_burst4_pkg;
`include "ddr_burst4_cfg.svh"
   typedef enum logic [1:0] {DLL_LOCKING, DLL_LOCKED, DLL_BYPASS} dll_e;
   typedef logic [20:0] addr_t;
   typedef logic [17:0] word_t;
   typedef logic [11:0] count_t;
endpackage : ddr_burst4_pkg

// File: logic/ddr_burst4_sram_port.sv
// Burst-of-four common-I/O SRAM device model with loop lock control and an Avalon status port.
// Assumes every SRAM pin, clocks included, is asynchronous to i_clk and much slower than it.
// Contract
// - Static input clock over 30 ns resets loop
// - Ready only after loop relocks
// - Bypass pin rising edge resets the loop
// - Burst addresses wrap low two bits linearly
// - Load low, read pin high starts read
// - Load low, read pin low starts write
// - Address loaded only when load strobe low
// - Read beats at t+1.5 through t+3.0
// - Read at cycle t, write t+1
// - Lane enables mask each nine-bit half
// - Lane enables sampled separately per beat
// - Lock after 2048 stable clock cycles
// - Idle drivers go high impedance, reads finish
// - Reads see the latest written data; a first read beat on the edge of a write's last beat reads the old word
`timescale 1ns/100ps
`default_nettype none
`include "ddr_burst4_cfg.svh"

module ddr_burst4_sram_port (
   // System clock and reset.
   input  wire logic                   i_clk,
   input  wire logic                   i_rst_n,
   // Avalon-MM register slave.
   input  wire logic [3:0]             i_address,
   input  wire logic                   i_read,
   input  wire logic                   i_write,
   input  wire logic [31:0]            i_writedata,
   input  wire logic [3:0]             i_byteenable,
   output logic [31:0]                 o_readdata,
   output logic                        o_waitrequest,
   // SRAM clocks and loop control.
   input  wire logic                   i_k,
   input  wire logic                   i_k_n,
   input  wire logic                   i_dll_off_n,
   // SRAM command, address and lane enables.
   input  wire logic                   i_load_strobe_n,
   input  wire logic                   i_rw,
   input  wire logic                   i_byte_lane_enable_n0,
   input  wire logic                   i_byte_lane_enable_n1,
   input  wire ddr_burst4_pkg::addr_t  i_addr,
   // SRAM common data bus.
   input  wire ddr_burst4_pkg::word_t  i_dq,
   output ddr_burst4_pkg::word_t       o_dq,
   output logic                        o_dq_oe_n
);
   import ddr_burst4_pkg::*;

   function automatic addr_t burst_addr(input addr_t base, input logic [1:0] beat);
      burst_addr = {base[20:2], 2'(base[1:0] + beat)};
   endfunction : burst_addr

   logic [45:0] sync1;
   logic [45:0] sync2;
   logic        k_s;
   logic        kn_s;
   logic        off_s;
   logic        ld_s;
   logic        rw_s;
   logic [1:0]  ben_s;
   addr_t       a_s;
   word_t       dq_s;
   logic        k_q;
   logic        kn_q;
   logic        off_q;

   // Every pin passes two flops; the slow link clock keeps data and edges aligned.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         sync1 <= 46'h0;
         sync2 <= 46'h0;
      end else begin
         sync1 <= {i_k, i_k_n, i_dll_off_n, i_load_strobe_n, i_rw,
                   i_byte_lane_enable_n1, i_byte_lane_enable_n0, i_addr, i_dq};
         sync2 <= sync1;
      end
   end

   assign {k_s, kn_s, off_s, ld_s, rw_s, ben_s, a_s, dq_s} = sync2;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         k_q   <= 1'b0;
         kn_q  <= 1'b0;
         off_q <= 1'b0;
      end else begin
         k_q   <= k_s;
         kn_q  <= kn_s;
         off_q <= off_s;
      end
   end

   logic k_rise;
   logic hedge;
   logic k_chg;
   logic off_rise;
   assign k_rise   = k_s & ~k_q;
   assign hedge    = k_rise | (kn_s & ~kn_q);
   assign k_chg    = (k_s ^ k_q) | (kn_s ^ kn_q);
   assign off_rise = off_s & ~off_q;

   // A stop is a gap longer than the last half period plus the stop time.
   // The clock rate is unknown here, so the half period is measured live.
   count_t half_cnt;
   count_t last_half;
   logic   seen;
   logic   stopped;
   logic   stop_now;
   logic   stop_ev;
   assign stop_now = seen & ~k_chg &
                     ({1'b0, half_cnt} > ({1'b0, last_half} + 13'(`STOP_CYC)));
   assign stop_ev  = stop_now & ~stopped;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         half_cnt  <= 12'h0;
         last_half <= 12'h0;
         seen      <= 1'b0;
         stopped   <= 1'b0;
      end else begin
         stopped <= stop_now;
         if (k_chg) begin
            half_cnt  <= 12'h0;
            last_half <= half_cnt;
            seen      <= 1'b1;
         end else if (half_cnt != 12'hFFF) begin
            half_cnt <= half_cnt + 12'h1;
         end
      end
   end

   dll_e   dll_st;
   count_t lock_cnt;
   logic   relock;
   logic   ctrl_en;
   logic   ready;
   assign ready = (dll_st != DLL_LOCKING);

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         dll_st   <= DLL_LOCKING;
         lock_cnt <= 12'h0;
      end else if (!off_s) begin
         dll_st   <= DLL_BYPASS;
         lock_cnt <= 12'h0;
      end else if (off_rise || stop_ev || relock) begin
         dll_st   <= DLL_LOCKING;
         lock_cnt <= 12'h0;
      end else begin
         unique case (dll_st)
            DLL_LOCKING: begin
               if (k_rise) begin
                  if (lock_cnt == 12'(`LOCK_KCYC - 1)) begin
                     dll_st <= DLL_LOCKED;
                  end else begin
                     lock_cnt <= lock_cnt + 12'h1;
                  end
               end
            end
            DLL_LOCKED, DLL_BYPASS: begin
            end
         endcase
      end
   end

   logic cmd;
   logic rd_cmd;
   logic wr_cmd;
   assign cmd    = k_rise & ~ld_s & ready & ctrl_en;
   assign rd_cmd = cmd & rw_s;
   assign wr_cmd = cmd & ~rw_s;

   addr_t      rd_cmd_addr;
   addr_t      rd_base;
   logic       rd_wait_v;
   logic [1:0] rd_wait;
   logic [1:0] rd_beat;
   logic       rd_act;
   logic       launch;
   addr_t      beat_addr;
   assign launch    = hedge & rd_wait_v & (rd_wait == `RD_WAIT_LAST);
   assign beat_addr = launch ? burst_addr(rd_cmd_addr, 2'h0) : burst_addr(rd_base, rd_beat);

   // The first read beat goes out on the third half-cycle edge after the command.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         rd_cmd_addr <= '0;
         rd_base     <= '0;
         rd_wait_v   <= 1'b0;
         rd_wait     <= 2'h0;
         rd_beat     <= 2'h0;
         rd_act      <= 1'b0;
      end else begin
         if (launch) begin
            rd_wait_v <= 1'b0;
            rd_act    <= 1'b1;
            rd_base   <= rd_cmd_addr;
            rd_beat   <= 2'h1;
         end else if (hedge && rd_act) begin
            rd_act  <= (rd_beat != 2'h3);
            rd_beat <= rd_beat + 2'h1;
         end
         if (hedge && rd_wait_v && !launch) begin
            rd_wait <= rd_wait + 2'h1;
         end
         if (rd_cmd) begin
            rd_wait_v   <= 1'b1;
            rd_wait     <= 2'h0;
            rd_cmd_addr <= a_s;
         end
      end
   end

   addr_t      wr_cmd_addr;
   addr_t      wr_base;
   logic       wr_wait_v;
   logic [1:0] wr_wait;
   logic [1:0] wr_beat;
   logic       wr_act;
   logic       wlaunch;
   logic       wbeat_go;
   addr_t      wbeat_addr;
   assign wlaunch    = hedge & wr_wait_v & (wr_wait == `WR_WAIT_LAST);
   assign wbeat_go   = wlaunch | (hedge & wr_act);
   assign wbeat_addr = wlaunch ? burst_addr(wr_cmd_addr, 2'h0) : burst_addr(wr_base, wr_beat);

   // Late write: the first beat is taken one full clock after the command.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         wr_cmd_addr <= '0;
         wr_base     <= '0;
         wr_wait_v   <= 1'b0;
         wr_wait     <= 2'h0;
         wr_beat     <= 2'h0;
         wr_act      <= 1'b0;
      end else begin
         if (wlaunch) begin
            wr_wait_v <= 1'b0;
            wr_act    <= 1'b1;
            wr_base   <= wr_cmd_addr;
            wr_beat   <= 2'h1;
         end else if (hedge && wr_act) begin
            wr_act  <= (wr_beat != 2'h3);
            wr_beat <= wr_beat + 2'h1;
         end
         if (hedge && wr_wait_v && !wlaunch) begin
            wr_wait <= wr_wait + 2'h1;
         end
         if (wr_cmd) begin
            wr_wait_v   <= 1'b1;
            wr_wait     <= 2'h0;
            wr_cmd_addr <= a_s;
         end
      end
   end

   // Beats land in the array as they arrive, so a following read returns the newest data without a bypass path,
   // except a first read beat fetched on the same edge as a write's last beat, which gets the old word.
   word_t mem [0:(1 << 21) - 1];

   always_ff @(posedge i_clk) begin
      if (wbeat_go) begin
         for (int lane = 0; lane < 2; lane++) begin
            if (!ben_s[lane]) begin
               mem[wbeat_addr][lane * `LANE_W +: `LANE_W] <= dq_s[lane * `LANE_W +: `LANE_W];
            end
         end
      end
   end

   // Outputs change only on link edges, so a stopped clock freezes the pins.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_dq      <= '0;
         o_dq_oe_n <= 1'b1;
      end else if (hedge) begin
         if (launch || rd_act) begin
            o_dq      <= mem[beat_addr];
            o_dq_oe_n <= 1'b0;
         end else begin
            o_dq_oe_n <= 1'b1;
         end
      end
   end

   logic  done;
   logic  ctrl_wr;
   logic [31:0] reg_mux;
   assign done    = (i_read | i_write) & ~o_waitrequest;
   assign ctrl_wr = done & i_write & (i_address == `REG_CTRL) & i_byteenable[0];

   always_comb begin
      reg_mux = 32'h0;
      unique case (i_address)
         `REG_STATUS: begin
            reg_mux[`ST_LOCKED]  = (dll_st == DLL_LOCKED);
            reg_mux[`ST_BYPASS]  = (dll_st == DLL_BYPASS);
            reg_mux[`ST_STOPPED] = stopped;
            reg_mux[`ST_BUSY]    = rd_act | wr_act | rd_wait_v | wr_wait_v;
         end
         `REG_CTRL: reg_mux[`CTRL_ENABLE] = ctrl_en;
         `REG_LOCKCNT: reg_mux[11:0] = lock_cnt;
         default: reg_mux = 32'h0;
      endcase
   end

   // One wait state per access; the answer stays in o_readdata until the next read.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_waitrequest <= 1'b1;
         o_readdata    <= 32'h0;
         ctrl_en       <= `CTRL_RESET;
         relock        <= 1'b0;
      end else begin
         o_waitrequest <= ~((i_read | i_write) & o_waitrequest);
         relock        <= ctrl_wr & i_writedata[`CTRL_RELOCK];
         if (i_read && o_waitrequest) begin
            o_readdata <= reg_mux;
         end
         if (ctrl_wr) begin
            ctrl_en <= i_writedata[`CTRL_ENABLE];
         end
      end
   end

   addr_t last_rd_addr;
   addr_t last_wr_addr;
   always_ff @(posedge i_clk) begin
      if (hedge && (launch || rd_act)) begin
         last_rd_addr <= beat_addr;
      end
      if (wbeat_go) begin
         last_wr_addr <= wbeat_addr;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_read_cmd;
      rd_cmd;
   endsequence
   sequence s_first_beat;
      $past(launch) && !o_dq_oe_n;
   endsequence

   chk_stop_relock: assert property (stop_ev && off_s |=> dll_st == DLL_LOCKING && lock_cnt == 12'h0)
      else $error("clock stop did not restart locking");
   chk_lock_time: assert property ($rose(dll_st == DLL_LOCKED) |->
                                   $past(lock_cnt) == 12'h7FF && $past(k_rise))
      else $error("lock reached at wrong count");
   chk_bypass_reset: assert property (off_rise |=> dll_st == DLL_LOCKING && lock_cnt == 12'h0)
      else $error("bypass release did not restart locking");
   chk_unlocked_ignore: assert property (dll_st == DLL_LOCKING |-> !cmd)
      else $error("command accepted while unlocked");
   chk_read_cmd: assert property (rd_cmd |=> rd_wait_v && rd_wait == 2'h0 && rd_cmd_addr == $past(a_s))
      else $error("read command not registered");
   chk_write_cmd: assert property (wr_cmd |=> wr_wait_v && wr_wait == 2'h0 && wr_cmd_addr == $past(a_s))
      else $error("write command not registered");
   chk_load_gate: assert property (k_rise && ld_s |=> $stable(rd_cmd_addr) && $stable(wr_cmd_addr))
      else $error("address loaded without strobe");
   chk_read_lat: assert property (s_read_cmd |-> ##[11:13] s_first_beat)
      else $error("first read beat late or missing");
   chk_burst_wrap: assert property (hedge && rd_act && !launch |->
                                    beat_addr == burst_addr(last_rd_addr, 2'h1))
      else $error("read burst address not linear");
   chk_lane_abort: assert property (wbeat_go && ben_s == 2'h3 ##1 1'b1 |->
                                    mem[last_wr_addr] == $past(mem[wbeat_addr]))
      else $error("aborted beat changed memory");
   chk_lane_write: assert property (wbeat_go && ben_s == 2'h2 |=>
                                    mem[last_wr_addr][8:0] == $past(dq_s[8:0]))
      else $error("lane zero not written");
   chk_idle_hiz: assert property (hedge && !launch && !rd_act |=> o_dq_oe_n)
      else $error("drivers left on with no read beat");

endmodule : ddr_burst4_sram_port
`default_nettype wire

// File: verification/sram_master_model.sv
// SRAM-side master model: K/K# clocks, burst commands and write beats.
// Assumes the bench resolves the shared data wire and may stop the clocks.
`timescale 1ns/100ps
`default_nettype none
module sram_master_model (
   // Clocks.
   output logic                  o_k,
   output logic                  o_k_n,
   // Command, address, lanes and data.
   output logic                  o_load_strobe_n,
   output logic                  o_rw,
   output logic [1:0]            o_lane_n,
   output ddr_burst4_pkg::addr_t o_addr,
   output ddr_burst4_pkg::word_t o_dq,
   input  wire ddr_burst4_pkg::word_t i_dq
);
   import ddr_burst4_pkg::*;
   logic run     = 1'b1;
   int   k_rises = 0;
   // Pins start at defined levels and a stopped clock rests high or low.
   initial begin
      o_k = 1'b0;
      o_load_strobe_n = 1'b1;
      o_rw = 1'b1;
      o_lane_n = 2'h3;
      o_addr = '0;
      o_dq = '0;
   end
   always #200 if (run) o_k = ~o_k;
   assign o_k_n = ~o_k;
   always @(posedge o_k) k_rises++;
   // A burst spans two K periods, so calls never come closer than two cycles.
   task automatic issue(input logic rd, input addr_t a);
      @(posedge o_k_n);
      o_load_strobe_n = 1'b0;
      o_rw = rd;
      o_addr = a;
      @(posedge o_k);
      #100;
      o_load_strobe_n = 1'b1;
      @(posedge o_k_n);
   endtask : issue
   task automatic write_burst(input addr_t a, input word_t [3:0] d, input logic [7:0] m);
      issue(1'b0, a);
      for (int i = 0; i < 4; i++) begin
         #100;
         o_dq = d[i];
         o_lane_n = m[2*i +: 2];
         if (i[0]) @(posedge o_k_n);
         else @(posedge o_k);
      end
      #100;
      o_dq = ~o_dq;
      o_lane_n = 2'h3;
   endtask : write_burst
   // Each beat is taken just after the following edge, once it has settled.
   task automatic read_burst(input addr_t a, output word_t [3:0] q);
      issue(1'b1, a);
      @(posedge o_k_n);
      for (int i = 0; i < 4; i++) begin
         if (i[0]) @(posedge o_k_n);
         else @(posedge o_k);
         #60;
         q[i] = i_dq;
      end
   endtask : read_burst
endmodule : sram_master_model
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench for the burst-of-four SRAM port and its Avalon status port.
// Assumes the design package and the SRAM-side master model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "ddr_burst4_cfg.svh"
module tb_top;
   import ddr_burst4_pkg::*;
   typedef struct packed {logic [1:0] s; word_t [3:0] d; logic [7:0] m;} row_s;
   logic        i_clk = 1'b0, i_rst_n = 1'b0, i_read = 1'b0, i_write = 1'b0;
   logic        i_dll_off_n = 1'b1;
   logic [3:0]  i_address = 4'h0;
   logic [31:0] i_writedata = 32'h0, o_readdata, d;
   logic        o_waitrequest, o_dq_oe_n, k, k_n, lds_n, rw;
   logic [1:0]  lane_n;
   addr_t       addr, a;
   word_t       o_dq, m_dq, dq_wire, last;
   word_t [3:0] q, e;
   int          fails = 0, compares = 0, drv = 0, n;
   row_s        rows [4] = '{'{2'h0, {18'h11111, 18'h22222, 18'h33333, 18'h04444}, 8'h00},
                             '{2'h1, {18'h15555, 18'h0AAAA, 18'h3C3C3, 18'h00F0F}, 8'h36},
                             '{2'h2, {18'h12345, 18'h2FEDC, 18'h05A5A, 18'h3A5A5}, 8'hC9},
                             '{2'h3, {18'h0FFFF, 18'h30000, 18'h1E1E1, 18'h21212}, 8'h6F}};
   always #25 i_clk = ~i_clk;
   always @(posedge i_clk) if (o_dq_oe_n === 1'b0) drv++;
   assign dq_wire = (o_dq_oe_n === 1'b0) ? o_dq : m_dq;
   ddr_burst4_sram_port dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_address(i_address),
      .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(4'hF),
      .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_k(k), .i_k_n(k_n),
      .i_dll_off_n(i_dll_off_n), .i_load_strobe_n(lds_n), .i_rw(rw),
      .i_byte_lane_enable_n0(lane_n[0]), .i_byte_lane_enable_n1(lane_n[1]), .i_addr(addr),
      .i_dq(dq_wire), .o_dq(o_dq), .o_dq_oe_n(o_dq_oe_n));
   sram_master_model master (.o_k(k), .o_k_n(k_n), .o_load_strobe_n(lds_n), .o_rw(rw),
      .o_lane_n(lane_n), .o_addr(addr), .o_dq(m_dq), .i_dq(dq_wire));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic av(input logic we, input logic [3:0] adr, input logic [31:0] wd);
      @(posedge i_clk);
      i_read <= ~we;
      i_write <= we;
      i_address <= adr;
      i_writedata <= wd;
      do @(posedge i_clk);
      while (o_waitrequest !== 1'b0);
      d = o_readdata;
      i_read <= 1'b0;
      i_write <= 1'b0;
   endtask : av
   function automatic word_t bg(input logic [1:0] w);
      return 18'h2AAAA ^ {16'h0, w};
   endfunction : bg
   function automatic word_t merge(input word_t old, input word_t nw, input logic [1:0] m);
      merge = old;
      if (!m[0]) merge[8:0] = nw[8:0];
      if (!m[1]) merge[17:9] = nw[17:9];
   endfunction : merge
   // A refused command must leave the bus undriven, so no data is compared then.
   task automatic rd_chk(input addr_t ad, input word_t [3:0] ex, input logic [31:0] beats);
      n = drv;
      master.read_burst(ad, q);
      #400;
      if (beats != 0) for (int i = 0; i < 4; i++) chk({14'h0, q[i]}, {14'h0, ex[i]}, "beat");
      chk(32'(drv - n), beats, "drive cycles");
      chk({31'h0, o_dq_oe_n}, 32'h1, "bus released");
   endtask : rd_chk
   task automatic end_sim();
      $display("Counts: %0d compares, %0d fails", compares, fails);
      if (fails == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_sim
   // Lock alone needs about 0.82 ms, so three milliseconds leaves ample margin.
   initial begin
      #3_000_000;
      fails++;
      $display("Error at %0t ns: watchdog expired", $time);
      end_sim();
   end
   initial begin
      repeat (8) @(posedge i_clk);
      chk({30'h0, o_waitrequest, o_dq_oe_n}, 32'h3, "reset outputs");
      i_rst_n <= 1'b1;
      master.k_rises = 0;
      av(1'b0, `REG_CTRL, 32'h0);
      chk(d, 32'h1, "control reset");
      av(1'b1, 4'hC, 32'hFFFFFFFF);
      av(1'b0, 4'hC, 32'h0);
      chk(d, 32'h0, "unmapped");
      rd_chk(21'h0, q, 32'h0);
      do av(1'b0, `REG_STATUS, 32'h0);
      while (d[`ST_LOCKED] !== 1'b1 && master.k_rises < 2200);
      chk(32'(master.k_rises inside {[2048:2056]}), 32'h1, "lock time");
      $display("Test reset and lock done");
      foreach (rows[r]) begin
         a = {19'(r), 2'h0};
         master.write_burst(a, {bg(2'h3), bg(2'h2), bg(2'h1), bg(2'h0)}, 8'h00);
         a[1:0] = rows[r].s;
         master.write_burst(a, rows[r].d, rows[r].m);
         for (int i = 0; i < 4; i++) begin
            e[i] = merge(bg(rows[r].s + 2'(i)), rows[r].d[i], rows[r].m[2*i +: 2]);
         end
         rd_chk(a, e, 32'h10);
         $display("Test burst row %0d done", r);
      end
      last = o_dq;
      master.run = 1'b0;
      #1000;
      chk({14'h0, o_dq}, {14'h0, last}, "held data");
      av(1'b0, `REG_STATUS, 32'h0);
      chk({31'h0, d[`ST_LOCKED]}, 32'h0, "loop restart");
      chk({31'h0, d[`ST_STOPPED]}, 32'h1, "stop seen");
      master.run = 1'b1;
      rd_chk(a, e, 32'h0);
      $display("Test clock stop done");
      @(posedge i_clk);
      i_dll_off_n <= 1'b0;
      repeat (8) @(posedge i_clk);
      av(1'b0, `REG_STATUS, 32'h0);
      chk({31'h0, d[`ST_BYPASS]}, 32'h1, "bypass");
      av(1'b1, `REG_CTRL, 32'h0);
      rd_chk(a, e, 32'h0);
      av(1'b1, `REG_CTRL, 32'h1);
      rd_chk(a, e, 32'h10);
      @(posedge i_clk);
      i_dll_off_n <= 1'b1;
      repeat (8) @(posedge i_clk);
      av(1'b0, `REG_STATUS, 32'h0);
      chk({30'h0, d[`ST_BYPASS], d[`ST_LOCKED]}, 32'h0, "relock start");
      repeat (40) @(posedge i_clk);
      av(1'b0, `REG_LOCKCNT, 32'h0);
      chk({31'h0, d[11:0] != 12'h0}, 32'h1, "lock counting");
      av(1'b1, `REG_CTRL, 32'h3);
      av(1'b0, `REG_LOCKCNT, 32'h0);
      chk(d, 32'h0, "relock restart");
      $display("Test bypass done");
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
